/* File: src/tsp_edge_sync.sv */
/*
 samples the count source on phase two and phase four and flags a selected transition.
 assumes input synchronous to clk_sys; phase strobes come from tsp_phase_gen.
*/
`timescale 1ns/10ps
module tsp_edge_sync
    import tsp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    input wire logic phaseTwo,
    input wire logic phaseFour,
    input wire logic sampleIn,
    input wire logic fallingSel,
    output logic edgeSeen
);
    typedef struct packed {
        logic cur;
        logic prev;
        logic hit;
    } tsp_es_state_t;
    tsp_es_state_t st, next_st;
    always_comb begin
        next_st = st;
        next_st.hit = 1'b0;
        if (phaseTwo || phaseFour) begin
            next_st.cur = sampleIn;
            next_st.prev = st.cur;
            // rising when edge_sel low, falling when high
            next_st.hit = fallingSel ? (st.cur && !sampleIn) : (!st.cur && sampleIn);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '{cur: 1'b0, prev: 1'b0, hit: 1'b0};
        end else if (ce) begin
            st <= next_st;
        end
    end
    assign edgeSeen = st.hit;
endmodule

/* File: src/tsp_phase_gen.sv */
/*
 four-phase generator: one phase per clk_sys cycle, one instruction cycle per four phases.
 assumes clk_sys is the oscillator and ce freezes it with the rest of the block.
*/
`timescale 1ns/10ps
module tsp_phase_gen
    import tsp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    output logic phaseTwo,
    output logic phaseFour,
    output logic cycleEnd
);
    typedef struct packed {
        tsp_phase_t phase;
    } tsp_pg_state_t;
    tsp_pg_state_t st, next_st;
    always_comb begin
        next_st = st;
        case (st.phase)
            TSP_PH1: next_st.phase = TSP_PH2;
            TSP_PH2: next_st.phase = TSP_PH3;
            TSP_PH3: next_st.phase = TSP_PH4;
            default: next_st.phase = TSP_PH1;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '{phase: TSP_PH1};
        end else if (ce) begin
            st <= next_st;
        end
    end
    assign phaseTwo = (st.phase == TSP_PH2);
    assign phaseFour = (st.phase == TSP_PH4);
    assign cycleEnd = (st.phase == TSP_PH4);
endmodule

/* File: src/tsp_pkg.sv */
/*
 timer with shared prescaler: register indices, config field positions, reset values, timing figures.
 assumes a host core that decodes instruction-level writes; phase strobes come from tsp_phase_gen.
*/
package tsp_pkg;
    localparam logic [4:0] TSP_ADDR_COUNT = 5'h01;
    localparam logic [7:0] TSP_CONFIG_RESET = 8'hff;
    localparam logic [5:0] TSP_DIR_RESET = 6'h3f;
    localparam logic [7:0] TSP_PRESCALE_RESET = 8'h00;
    localparam int TSP_BIT_SOURCE = 5;
    localparam int TSP_BIT_EDGE = 4;
    localparam int TSP_BIT_ASSIGN = 3;
    localparam int TSP_RATIO_MSB = 2;
    localparam int TSP_PIN_SHARED = 2;
    localparam logic [1:0] TSP_INHIBIT_CYCLES = 2'h2;
    localparam int TSP_SYS_PERIOD_NS = 20;
    localparam int TSP_MARGIN_NS = 20;
    localparam int TSP_MARGIN_CYCLES = (TSP_MARGIN_NS + TSP_SYS_PERIOD_NS - 1) / TSP_SYS_PERIOD_NS;
    typedef enum logic [1:0] {TSP_PH1, TSP_PH2, TSP_PH3, TSP_PH4} tsp_phase_t;
endpackage

/* File: src/tsp_timer.sv */
/*
 timer/counter with 8-bit prescaler shared with the watchdog.
 assumes the core supplies one-cycle write strobes, aligned to the instruction cycle end, and
 the watchdog-clear instruction strobe; the watchdog itself lives outside and takes wdtTick.
*/
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - source bit zero counts instruction cycles
// - count write stalls counting two cycles
// - source bit one counts external pin edges
// - edge bit zero rising, one falling
// - assign bit picks counter or watchdog
// - ratio bits divide 1:2 through 1:256
// - prescaler never readable nor writable
// - sample count source on phases two, four
// - increment two to four clk_sys periods after edge
// - counter mode forces shared pin input
// - count write clears counter-assigned prescaler
// - watchdog clear clears watchdog-assigned prescaler
// - reset zeroes the prescaler
// - 8-bit prescaler before counter or after watchdog
// - count register read/write at address 01h
module tsp_timer
    import tsp_pkg::*;
#(
    parameter int COUNT_WIDTH = 8,
    parameter int PRESCALE_WIDTH = 8
)(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    input wire logic [4:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic configWrite,
    input wire logic [7:0] configWdata,
    input wire logic dirWrite,
    input wire logic [5:0] dirWdata,
    input wire logic watchdogClearInstr,
    input wire logic watchdogRawTick,
    input wire logic extCountInput,
    output logic wdtTick,
    output logic [5:0] pinOutputDisable,
    output logic countSourceExt
);
    import tsp_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [COUNT_WIDTH-1:0] count;
        logic [PRESCALE_WIDTH-1:0] prescale;
        logic [7:0] cfg;
        logic pinPrev;
        logic [5:0] dir;
        logic [1:0] inhibit;
        logic prescOut;
        logic wdtTick;
        logic [5:0] pinDis;
        logic srcExt;
        logic [7:0] rdata;
    } tsp_state_t;
    tsp_state_t st, next_st;
    logic phaseTwo;
    logic phaseFour;
    logic cycleEnd;
    logic edgeSeen;
    logic countWrite;
    logic toCounter;
    logic extMode;
    logic sampleSrc;
    logic prescTap;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic ratioTap(input logic [PRESCALE_WIDTH-1:0] p, input logic [2:0] r);
        ratioTap = p[r];
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    tsp_phase_gen u_phase (
        .clk_sys(clk_sys),
        .reset(reset),
        .ce(ce),
        .phaseTwo(phaseTwo),
        .phaseFour(phaseFour),
        .cycleEnd(cycleEnd)
    );
    // prescaled input is already symmetric, so the same sampler serves both paths
    tsp_edge_sync u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .ce(ce),
        .phaseTwo(phaseTwo),
        .phaseFour(phaseFour),
        .sampleIn(sampleSrc),
        .fallingSel(st.cfg[TSP_BIT_EDGE]),
        .edgeSeen(edgeSeen)
    );
    ////////////////////////////////////////////////////////////////////////////
    assign countWrite = regWrite && (regAddr == TSP_ADDR_COUNT);
    assign toCounter = !st.cfg[TSP_BIT_ASSIGN];
    assign extMode = st.cfg[TSP_BIT_SOURCE];
    assign prescTap = ratioTap(st.prescale, st.cfg[TSP_RATIO_MSB:0]);
    // prescaler modeled as synchronous counter; tap toggles like the ripple output
    assign sampleSrc = toCounter ? st.prescOut : extCountInput;
    always_comb begin
        logic tickIn;
        logic countTick;
        logic extEdge;
        tickIn = 1'b0;
        countTick = 1'b0;
        extEdge = 1'b0;
        next_st = st;
        next_st.wdtTick = 1'b0;
        next_st.pinPrev = extCountInput;
        // pin edge clocks the prescaler in counter mode with the prescaler assigned to the counter, standing in for the ripple stage
        extEdge = st.cfg[TSP_BIT_EDGE] ? (st.pinPrev && !extCountInput) : (!st.pinPrev && extCountInput);
        if (toCounter) begin
            tickIn = extMode ? extEdge : cycleEnd;
        end else begin
            tickIn = watchdogRawTick;
        end
        if (tickIn) begin
            next_st.prescale = st.prescale + 1'b1;
        end
        next_st.prescOut = ratioTap(next_st.prescale, st.cfg[TSP_RATIO_MSB:0]);
        if (!toCounter && tickIn && prescTap && !next_st.prescOut) begin
            next_st.wdtTick = 1'b1;
        end
        if (extMode) begin
            countTick = edgeSeen;
        end else if (toCounter) begin
            countTick = cycleEnd && prescTap && !next_st.prescOut;
        end else begin
            countTick = cycleEnd;
        end
        if (st.inhibit != 2'h0 && cycleEnd) begin
            next_st.inhibit = st.inhibit - 2'h1;
        end
        if (countWrite) begin
            next_st.count = regWdata;
            next_st.inhibit = TSP_INHIBIT_CYCLES;
            if (toCounter) begin
                next_st.prescale = TSP_PRESCALE_RESET;
                next_st.prescOut = 1'b0;
            end
        end else if (countTick && st.inhibit == 2'h0) begin
            next_st.count = st.count + 1'b1;
        end
        if (watchdogClearInstr && !toCounter) begin
            next_st.prescale = TSP_PRESCALE_RESET;
            next_st.prescOut = 1'b0;
        end
        if (configWrite) begin
            next_st.cfg = configWdata;
        end
        if (dirWrite) begin
            next_st.dir = dirWdata;
        end
        next_st.srcExt = next_st.cfg[TSP_BIT_SOURCE];
        next_st.pinDis = next_st.dir;
        next_st.pinDis[TSP_PIN_SHARED] = next_st.dir[TSP_PIN_SHARED] | next_st.cfg[TSP_BIT_SOURCE];
        // prescaler never appears on the read path
        next_st.rdata = (regAddr == TSP_ADDR_COUNT) ? next_st.count : 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st.count <= '0;
            st.prescale <= TSP_PRESCALE_RESET;
            st.cfg <= TSP_CONFIG_RESET;
            st.pinPrev <= 1'b0;
            st.dir <= TSP_DIR_RESET;
            st.inhibit <= 2'h0;
            st.prescOut <= 1'b0;
            st.wdtTick <= 1'b0;
            st.pinDis <= TSP_DIR_RESET;
            st.srcExt <= 1'b1;
            st.rdata <= 8'h00;
        end else if (ce) begin
            st <= next_st;
        end
    end
    assign regRdata = st.rdata;
    assign wdtTick = st.wdtTick;
    assign pinOutputDisable = st.pinDis;
    assign countSourceExt = st.srcExt;
    ////////////////////////////////////////////////////////////////////////////
    chk_reset_presc_zero: assert property (@(posedge clk_sys) reset |=> st.prescale == 8'h00)
        else $error("prescaler not zero after reset");
    chk_write_inhibit: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && countWrite) |=> st.inhibit == 2'h2)
        else $error("count write did not arm inhibit");
    chk_write_clears_presc: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && countWrite && toCounter && !configWrite) |=> st.prescale == 8'h00)
        else $error("count write left prescaler");
    chk_wdt_clear_presc: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && watchdogClearInstr && !toCounter && !configWrite) |=> st.prescale == 8'h00)
        else $error("watchdog clear left prescaler");
    chk_pin_forced_in: assert property (@(posedge clk_sys) disable iff (reset)
        (st.cfg[TSP_BIT_SOURCE] && !configWrite) |=> pinOutputDisable[TSP_PIN_SHARED])
        else $error("shared pin not forced input");
    chk_wdt_quiet: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && toCounter && !configWrite) |=> !wdtTick)
        else $error("watchdog tick while prescaler on counter");
    chk_count_step: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && !countWrite) |=> (st.count == $past(st.count)) || (st.count == $past(st.count) + 8'h01))
        else $error("count jumped by more than one");
    chk_timer_increment: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && !extMode && !toCounter && cycleEnd && st.inhibit == 2'h0 && !countWrite)
        |=> st.count == $past(st.count) + 8'h01)
        else $error("timer mode missed increment");
    chk_read_count: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && regAddr == TSP_ADDR_COUNT) |=> regRdata == st.count)
        else $error("count read mismatch");
    chk_inhibit_hold: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && st.inhibit != 2'h0 && !countWrite) |=> st.count == $past(st.count))
        else $error("counted during inhibit");
endmodule

/* File: testbench/tb_top.sv */
/*
 self-checking bench for tsp_timer.
 assumes tsp_pkg and the design files are compiled first; ce is tied high.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    import tsp_pkg::*;
    logic clk_sys = 0, reset = 1, regWrite = 0, configWrite = 0, dirWrite = 0;
    logic watchdogClearInstr = 0, watchdogRawTick = 0, wdtTick, countSourceExt, extCountInput;
    logic [4:0] regAddr = TSP_ADDR_COUNT;
    logic [7:0] regWdata = 8'h00, configWdata = 8'h00, regRdata, a;
    logic [5:0] dirWdata = 6'h00, pinOutputDisable;
    int errors = 0, samples_checked = 0, wdtSeen = 0;
    tsp_timer uut(.clk_sys(clk_sys), .reset(reset), .ce(1'b1), .regAddr(regAddr), .regWrite(regWrite),
        .regWdata(regWdata), .regRdata(regRdata), .configWrite(configWrite), .configWdata(configWdata),
        .dirWrite(dirWrite), .dirWdata(dirWdata), .watchdogClearInstr(watchdogClearInstr),
        .watchdogRawTick(watchdogRawTick), .extCountInput(extCountInput), .wdtTick(wdtTick),
        .pinOutputDisable(pinOutputDisable), .countSourceExt(countSourceExt));
    tsp_pulse_src src(.clk_sys(clk_sys), .pinLevel(extCountInput));
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (wdtTick === 1'b1) wdtSeen++;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr_count(input logic [7:0] d);
        regWdata = d;
        regWrite = 1;
        tick(1);
        regWrite = 0;
    endtask
    task automatic wr_cfg(input logic [7:0] d);
        configWdata = d;
        configWrite = 1;
        tick(1);
        configWrite = 0;
    endtask
    // watchdog cleared, then count, then config
    task automatic reassign(input logic [7:0] d);
        watchdogClearInstr = 1;
        tick(1);
        watchdogClearInstr = 0;
        wr_count(8'h00);
        wr_cfg(d);
    endtask
    task automatic rate(input logic [7:0] cfg, input int per);
        reassign(cfg);
        tick(16 + per);
        a = regRdata;
        tick(4 * per);
        `CHK(regRdata, a + 8'h04)
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        `CHK(regRdata, 8'h00)
        `CHK(pinOutputDisable, TSP_DIR_RESET)
        `CHK(countSourceExt, 1'b1)
        $display("test reset done");
    endtask
    task automatic test_timer;
        reassign(8'h08);
        dirWdata = 6'h00;
        dirWrite = 1;
        tick(1);
        dirWrite = 0;
        tick(2);
        `CHK(pinOutputDisable, 6'h00)
        wr_count(8'hfd);
        tick(2);
        `CHK(regRdata, 8'hfd)
        tick(6);
        a = regRdata;
        tick(40);
        `CHK(regRdata, a + 8'h0a)
        regAddr = 5'h02;
        wr_count(8'h55);
        tick(1);
        `CHK(regRdata, 8'h00)
        regAddr = TSP_ADDR_COUNT;
        $display("test timer done");
    endtask
    task automatic test_prescale;
        for (int r = 0; r < 8; r++) begin
            rate({5'h00, 3'(r)}, 4 * (2 << r));
        end
        rate(8'h0f, 4);
        $display("test prescale done");
    endtask
    task automatic test_counter;
        for (int e = 0; e < 2; e++) begin
            reassign(e ? 8'h38 : 8'h28);
            // wait out the two-cycle stall after the count write
            tick(10);
            `CHK(countSourceExt, 1'b1)
            `CHK(pinOutputDisable[TSP_PIN_SHARED], 1'b1)
            a = regRdata;
            src.step(1'b1);
            tick(10);
            `CHK(regRdata, a + (e ? 8'h00 : 8'h01))
            src.step(1'b0);
            tick(10);
            `CHK(regRdata, a + 8'h01)
            src.pulses(5);
            tick(10);
            `CHK(regRdata, a + 8'h06)
        end
        reassign(8'h20);
        tick(10);
        a = regRdata;
        src.pulses(4);
        tick(10);
        `CHK(regRdata, a + 8'h02)
        $display("test counter done");
    endtask
    task automatic test_wdt(input logic [7:0] cfg, input int expTicks);
        reassign(cfg);
        wdtSeen = 0;
        repeat (64) begin
            watchdogRawTick = 1;
            tick(1);
            watchdogRawTick = 0;
            tick(1);
        end
        `CHK(wdtSeen, expTicks)
        $display("test watchdog done");
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        tick(3);
        reset = 0;
        tick(1);
        test_reset();
        test_timer();
        test_prescale();
        test_counter();
        test_wdt(8'h00, 0);
        test_wdt(8'h08, 32);
        report_and_stop();
    end
endmodule

/* File: testbench/tsp_pulse_src.sv */
/*
 partner model: pulse source on the external count pin.
 assumes the bench calls its tasks from just after a clk_sys edge.
*/
`timescale 1ns/10ps
module tsp_pulse_src
    import tsp_pkg::*;
(
    input wire logic clk_sys,
    output logic pinLevel
);
    import tsp_pkg::*;
    // one spare cycle on top of the minimum, steps ignore phase while sampling is on phases two and four
    localparam int HOLD = 3 + TSP_MARGIN_CYCLES;
    initial pinLevel = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input logic lvl);
        pinLevel = lvl;
        repeat (HOLD) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            step(1'b1);
            step(1'b0);
        end
    endtask
endmodule
